// ### hdl/fihg_pkg.sv
// fast input request gate: shared constants and types
// assumes a single 100 MHz clock domain
package fihg_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned CYCLE_TIME_US    = 1000;
   localparam int unsigned CYCLE_TICKS      = CYCLE_TIME_US * CLK_MHZ;
   localparam int signed   COMP_MAX_US      = 5000000;
   localparam int signed   COMP_MIN_US      = -5000000;
   localparam int unsigned COMP_W           = 32;
   localparam int unsigned TICK_W           = 32;
   // ----------------------------------------
   // flag location space
   // ----------------------------------------
   localparam int unsigned LOC_W            = 17;
   localparam logic [16:0] LOC_BIT_MAX      = 17'h0_1FFF;
   localparam logic [16:0] LOC_XFER_BASE    = 17'h0_9C40;
   localparam logic [3:0]  DI_FIXED_LO      = 4'h4;
   localparam logic [1:0]  SPACE_BIT        = 2'h0;
   localparam logic [1:0]  SPACE_DI         = 2'h1;
   localparam logic [1:0]  SPACE_XFER       = 2'h2;
   // ----------------------------------------
   // reset values and interrupt bits
   // ----------------------------------------
   localparam logic [2:0]  IRQ_RST          = 3'h0;
   localparam int unsigned IRQ_TRIG         = 0;
   localparam int unsigned IRQ_IGN          = 1;
   localparam int unsigned IRQ_CLR          = 2;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_STAT         = 8'h04;
   localparam logic [7:0]  REG_COMP         = 8'h08;
   localparam logic [7:0]  REG_LOC          = 8'h0C;
   localparam logic [7:0]  REG_IRQ_ST       = 8'h10;
   localparam logic [7:0]  REG_IRQ_MSK      = 8'h14;
   localparam logic [7:0]  REG_TICK         = 8'h18;
   localparam logic [2:0]  ACT_CLUTCH       = 3'h0;

   typedef enum logic [1:0] {
      FIHG_IDLE  = 2'b00,
      FIHG_DELAY = 2'b01,
      FIHG_FIRE  = 2'b10
   } fihg_state_t;
endpackage

// ### hdl/fihg_sync.sv
// three-flop synchroniser for the raw request pin
// assumes the pin is asynchronous to CLK
`timescale 1ns/1ps
module fihg_sync
   import fihg_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic o;
   } fihg_sync_t;
   fihg_sync_t q, d;

   always_comb begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a level change counts only once stages two and three agree
      if (q.s2 == q.s3) begin
         d.o = q.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.o;
endmodule

// ### hdl/fihg_loc_check.sv
// checks that a flag location lies in a usable bit space
// assumes location code is static between writes
`timescale 1ns/1ps
module fihg_loc_check
   import fihg_pkg::*;
(
   input  wire logic [1:0]  space,
   input  wire logic [16:0] loc,
   output logic             usable
);
   always_comb begin
      case (space)
         SPACE_BIT:  usable = (loc <= LOC_BIT_MAX);
         // positions 4..F of the built-in input block are hard zero
         SPACE_DI:   usable = (loc[3:0] < DI_FIXED_LO);
         SPACE_XFER: usable = (loc >= LOC_XFER_BASE);
         default:    usable = 1'b0;
      endcase
   end
endmodule

// ### hdl/fihg_top.sv
// fast input request gate: edge detect, enable flag gating, status mirror
// assumes a plain register port and one 100 MHz clock
//
// How it works
// - act on a detected request edge only while the enable flag is on
// - with the flag off, detections are ignored and nothing fires
// - an omitted flag location means the request is always enabled
// - the flag is sampled at the detection moment to decide validity
// - the synchronised input level is copied to status once per operation cycle
// - status follows the input whatever the enable flag says
// - flag clears when input arrives while sync control or encoder request off
// - flag locations: bit space 0..1FFF/8191 or transfer area from word 9C40/40000
// - built-in input positions 4..F read zero and cannot hold a flag
// - a valid request fires clutch, counter enable/disable or value change
// - timing delays by compensation up to 5000000 us, negative values fire at once, status unaffected
`timescale 1ns/1ps
module fihg_top
   import fihg_pkg::*;
#(
   parameter int unsigned TICK_DEFAULT = CYCLE_TICKS
)
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        REQ_IN,
   input  wire logic        SYNC_CONTROL_ACTIVE,
   input  wire logic        ENCODER_AXIS_CONTROL_REQUEST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   output logic             ACT_PULSE,
   output logic [2:0]       ACT_KIND,
   output logic             STATUS_BIT,
   output logic             ENABLE_FLAG,
   output logic             IRQ
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      fihg_state_t      st;
      logic             flag_used;
      logic             flag;
      logic [1:0]       space;
      logic [16:0]      loc;
      logic [2:0]       kind;
      logic [31:0]      comp;
      logic [31:0]      tick_len;
      logic [31:0]      tick_cnt;
      logic [31:0]      wait_cnt;
      logic             lvl_prev;
      logic             edge_pend;
      logic             edge_neg;
      logic             status;
      logic [2:0]       irq_st;
      logic [2:0]       irq_msk;
      logic [31:0]      rdata;
      logic             act;
      logic             irq;
   } fihg_t;
   fihg_t q, d;

   logic req_lvl;
   logic loc_ok;
   logic tick;
   logic flag_eff;
   logic inhibit;
   logic [31:0] comp_ticks;
   logic signed [31:0] comp_sat;
   logic [2:0] ev;

   fihg_sync u_sync (
      .clk  (CLK),
      .rst  (SYS_RST),
      .din  (REQ_IN),
      .dout (req_lvl)
   );

   fihg_loc_check u_loc (
      .space  (q.space),
      .loc    (q.loc),
      .usable (loc_ok)
   );

   assign tick = (q.tick_cnt == 32'h0000_0000);

   always_comb begin
      if ($signed(q.comp) > COMP_MAX_US) begin
         comp_sat = COMP_MAX_US;
      end else if ($signed(q.comp) < COMP_MIN_US) begin
         comp_sat = COMP_MIN_US;
      end else begin
         comp_sat = $signed(q.comp);
      end
   end

   // positive delay only; a negative value cannot be undone in hardware, it fires at once
   assign comp_ticks = (comp_sat > 0) ? 32'(comp_sat / 32'(CYCLE_TIME_US)) : 32'h0000_0000;

   // unusable location reads as constant zero
   assign flag_eff = !q.flag_used ? 1'b1 : (loc_ok & q.flag);
   assign inhibit  = !SYNC_CONTROL_ACTIVE || !ENCODER_AXIS_CONTROL_REQUEST;

   always_comb begin
      d        = q;
      d.act    = 1'b0;
      d.rdata  = 32'h0000_0000;
      ev       = 3'h0;
      d.lvl_prev = req_lvl;

      d.tick_cnt = tick ? (q.tick_len - 32'h0000_0001) : (q.tick_cnt - 32'h0000_0001);

      // latch any rising edge until the next tick
      if (req_lvl && !q.lvl_prev) begin
         d.edge_pend = 1'b1;
      end

      // ---------------- register writes ----------------
      if (WR) begin
         case (ADDR)
            REG_CTRL: begin
               d.flag      = WDATA[0];
               d.flag_used = WDATA[1];
               d.kind      = WDATA[6:4];
            end
            REG_COMP:    d.comp = WDATA;
            REG_LOC: begin
               d.loc   = WDATA[16:0];
               d.space = WDATA[21:20];
            end
            REG_IRQ_MSK: d.irq_msk = WDATA[2:0];
            REG_TICK:    d.tick_len = (WDATA == 32'h0000_0000) ? 32'h0000_0001 : WDATA;
            default: ;
         endcase
      end

      // ---------------- operation-cycle work ----------------
      if (tick) begin
         d.status = req_lvl;
         if (q.edge_pend || (req_lvl && !q.lvl_prev)) begin
            d.edge_pend = 1'b0;
            if (inhibit) begin
               d.flag = 1'b0;
               ev[IRQ_CLR] = 1'b1;
            end else if (flag_eff) begin
               if (q.st == FIHG_IDLE) begin
                  d.st       = (comp_ticks == 32'h0000_0000) ? FIHG_FIRE : FIHG_DELAY;
                  d.wait_cnt = comp_ticks;
               end
            end else begin
               ev[IRQ_IGN] = 1'b1;
            end
         end
      end

      case (q.st)
         FIHG_IDLE: ;
         FIHG_DELAY: begin
            if (tick) begin
               d.wait_cnt = q.wait_cnt - 32'h0000_0001;
               if (q.wait_cnt <= 32'h0000_0001) begin
                  d.st = FIHG_FIRE;
               end
            end
         end
         FIHG_FIRE: begin
            d.act = 1'b1;
            ev[IRQ_TRIG] = 1'b1;
            d.st = FIHG_IDLE;
         end
         default: d.st = FIHG_IDLE;
      endcase

      // ---------------- interrupts: set beats clear ----------------
      if (WR && ADDR == REG_IRQ_ST) begin
         d.irq_st = q.irq_st & ~WDATA[2:0];
      end
      d.irq_st = d.irq_st | ev;
      d.irq    = |(d.irq_st & q.irq_msk);

      // ---------------- register reads ----------------
      if (RD) begin
         case (ADDR)
            REG_CTRL:    d.rdata = {25'h000_0000, q.kind, 2'h0, q.flag_used, q.flag};
            REG_STAT:    d.rdata = {28'h000_0000, loc_ok, q.st == FIHG_DELAY, q.edge_pend, q.status};
            REG_COMP:    d.rdata = q.comp;
            REG_LOC:     d.rdata = {10'h000, q.space, 3'h0, q.loc};
            REG_IRQ_ST:  d.rdata = {29'h0000_0000, q.irq_st};
            REG_IRQ_MSK: d.rdata = {29'h0000_0000, q.irq_msk};
            REG_TICK:    d.rdata = q.tick_len;
            default:     d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         q          <= '0;
         q.st       <= FIHG_IDLE;
         q.kind     <= ACT_CLUTCH;
         q.tick_len <= TICK_DEFAULT;
         q.tick_cnt <= 32'h0000_0000;
         q.irq_st   <= IRQ_RST;
         q.irq_msk  <= IRQ_RST;
      end else begin
         q <= d;
      end
   end

   // software re-arms the flag through the control register
   assign RDATA       = q.rdata;
   assign ACT_PULSE   = q.act;
   assign ACT_KIND    = q.kind;
   assign STATUS_BIT  = q.status;
   assign ENABLE_FLAG = q.flag;
   assign IRQ         = q.irq;
endmodule

// ### verification/fihg_sensor.sv
// sensor model driving the raw request pin
// assumes the bench sets the wanted level just after clock edges
`timescale 1ns/1ps
module fihg_sensor #(
   parameter int LAG = 3
)
(
   input  wire logic clk,
   input  wire logic level,
   output logic      req
);
   // fixed wire and filter lag of a real sensor, not zero on purpose
   logic [LAG-1:0] pipe_q = '0;
   always_ff @(posedge clk) begin
      pipe_q <= {pipe_q[LAG-2:0], level};
   end
   assign req = pipe_q[LAG-1];
endmodule

// ### verification/fihg_checker.sv
// port-level properties of the request gate
// assumes the cycle length stays at TICK_DEFAULT of 8 clocks
`timescale 1ns/1ps
module fihg_checker
   import fihg_pkg::*;
(
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic        REQ_IN,
   input wire logic        SYNC_CONTROL_ACTIVE,
   input wire logic        ENCODER_AXIS_CONTROL_REQUEST,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        ACT_PULSE,
   input wire logic [2:0]  ACT_KIND,
   input wire logic        STATUS_BIT,
   input wire logic        ENABLE_FLAG,
   input wire logic        IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_req_hi;
      REQ_IN [*8] ##1 REQ_IN [*8];
   endsequence
   sequence s_req_lo;
      !REQ_IN [*8] ##1 !REQ_IN [*8];
   endsequence
   AST_PULSE_ONE: assert property (ACT_PULSE |=> !ACT_PULSE)
      else $error("action pulse longer than one cycle");
   AST_FIRE_ENABLED: assert property (ACT_PULSE |-> $past(SYNC_CONTROL_ACTIVE, 2) &&
      $past(ENCODER_AXIS_CONTROL_REQUEST, 2)) else $error("action fired while inhibited");
   AST_FLAG_FALL: assert property ($fell(ENABLE_FLAG) |-> $past(WR) ||
      !$past(SYNC_CONTROL_ACTIVE) || !$past(ENCODER_AXIS_CONTROL_REQUEST)) else $error("flag fell without cause");
   AST_FLAG_RISE: assert property ($rose(ENABLE_FLAG) |-> $past(WR) && $past(ADDR) == REG_CTRL
      && $past(WDATA[0])) else $error("flag rose without a program write");
   AST_KIND_STABLE: assert property (!$past(WR) |-> $stable(ACT_KIND))
      else $error("action kind changed without a write");
   AST_STATUS_HOLD: assert property ($changed(STATUS_BIT) |=> $stable(STATUS_BIT) [*7])
      else $error("status changed between cycle ticks");
   AST_STATUS_HI: assert property (s_req_hi |-> STATUS_BIT)
      else $error("status missed a high input");
   AST_STATUS_LO: assert property (s_req_lo |-> !STATUS_BIT)
      else $error("status missed a low input");
   AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside read slot");
   AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
      else $error("interrupt dropped without a write");
endmodule
bind fihg_top fihg_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .REQ_IN(REQ_IN),
   .SYNC_CONTROL_ACTIVE(SYNC_CONTROL_ACTIVE), .ENCODER_AXIS_CONTROL_REQUEST(ENCODER_AXIS_CONTROL_REQUEST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ACT_PULSE(ACT_PULSE),
   .ACT_KIND(ACT_KIND), .STATUS_BIT(STATUS_BIT), .ENABLE_FLAG(ENABLE_FLAG), .IRQ(IRQ));

// ### verification/tb_top.sv
// testbench: register tasks and request edges through the sensor model
// assumes TICK_DEFAULT shortened to 8 clocks
`timescale 1ns/1ps
module tb_top
   import fihg_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, lvl = 1'b0, sca = 1'b1, enc = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        req, act, stat, flag, irq;
   logic [2:0]  kind;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, v;
   logic [31:0] locs [7] = '{32'h0000_0000, 32'h0000_1FFF, 32'h0000_2000, 32'h0010_0003,
                             32'h0010_0004, 32'h0020_9C40, 32'h0020_9C3F};
   int          fires [7] = '{1, 1, 0, 1, 0, 1, 0};
   int          errors = 0, total_checks = 0, n, d, d0;
   always #5 clk = ~clk;
   fihg_sensor u_sen (.clk(clk), .level(lvl), .req(req));
   fihg_top #(.TICK_DEFAULT(8)) dut (.CLK(clk), .SYS_RST(rst), .REQ_IN(req), .SYNC_CONTROL_ACTIVE(sca),
      .ENCODER_AXIS_CONTROL_REQUEST(enc), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .ACT_PULSE(act), .ACT_KIND(kind), .STATUS_BIT(stat), .ENABLE_FLAG(flag), .IRQ(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk);
      addr <= a;
      wdata <= dat;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   // one rising request edge: pulses seen, and clocks from the status rise to the first pulse
   // status rises at the detecting tick, so the delay does not depend on the tick phase
   task automatic req_edge(output int cnt, output int dly);
      int s0;
      cnt = 0;
      dly = 0;
      s0 = -1;
      @(posedge clk);
      lvl <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         if (stat === 1'b1 && s0 < 0) s0 = i;
         if (act === 1'b1) begin
            cnt++;
            if (cnt == 1) dly = i - s0;
         end
      end
      @(posedge clk);
      lvl <= 1'b0;
      repeat (24) @(posedge clk);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_reg(REG_CTRL, v);
      chk(v, 32'h0000_0000);
      rd_reg(8'h40, v);
      chk(v, 32'h0000_0000);
      wr_reg(REG_IRQ_MSK, 32'h0000_0007);
      req_edge(n, d0);
      chk(n, 1);
      chk(d0, 1);
      chk({31'h0, irq}, 32'h0000_0001);
      wr_reg(REG_IRQ_ST, 32'h0000_0007);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      // flag locations and action kinds in one sweep
      for (int i = 0; i < 7; i++) begin
         wr_reg(REG_CTRL, 32'h0000_0003 | (i << 4));
         wr_reg(REG_LOC, locs[i]);
         req_edge(n, d);
         chk(n, fires[i]);
         chk({29'h0, kind}, i);
      end
      wr_reg(REG_LOC, 32'h0000_0000);
      wr_reg(REG_CTRL, 32'h0000_0002);
      req_edge(n, d);
      chk(n, 0);
      rd_reg(REG_IRQ_ST, v);
      chk(v & 32'h0000_0002, 32'h0000_0002);
      @(posedge clk) lvl <= 1'b1;
      repeat (30) @(posedge clk);
      chk({31'h0, stat}, 32'h0000_0001);
      lvl <= 1'b0;
      repeat (30) @(posedge clk);
      chk({31'h0, stat}, 32'h0000_0000);
      // each inhibit input clears the flag; the program sets it again
      for (int j = 0; j < 2; j++) begin
         wr_reg(REG_CTRL, 32'h0000_0003);
         @(posedge clk) {sca, enc} <= j ? 2'b10 : 2'b01;
         req_edge(n, d);
         chk(n, 0);
         chk({31'h0, flag}, 32'h0000_0000);
         rd_reg(REG_IRQ_ST, v);
         chk(v & 32'h0000_0004, 32'h0000_0004);
         @(posedge clk) {sca, enc} <= 2'b11;
         wr_reg(REG_CTRL, 32'h0000_0003);
         #1 chk({31'h0, flag}, 32'h0000_0001);
      end
      wr_reg(REG_CTRL, 32'h0000_0000);
      wr_reg(REG_COMP, 32'h0000_07D0);
      req_edge(n, d);
      chk(n, 1);
      chk({31'h0, d > d0 + 12}, 32'h0000_0001);
      wr_reg(REG_COMP, 32'hFFFF_F448);
      req_edge(n, d);
      chk({31'h0, n == 1 && d < d0 + 9}, 32'h0000_0001);
      wr_reg(REG_CTRL, 32'h0000_0003);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk({31'h0, flag}, 32'h0000_0000);
      end_sim();
   end
endmodule
